// [crc_link_pkg.sv]
package crc_link_pkg;
    localparam int crc_width = 16;
    localparam int data_width = 8;
    // apb byte addresses
    localparam logic [7:0] param_reg_addr = 8'h00;
    localparam logic [7:0] ctrl_reg_addr = 8'h04;
    localparam logic [7:0] rxbuf_reg_addr = 8'h08;
    localparam logic [7:0] txcrc_reg_addr = 8'h0c;
    localparam logic [7:0] rxcrc_reg_addr = 8'h10;
    // parameter register fields
    localparam int byte_count_protocol_bit = 15;
    // control register fields
    localparam int crc_disable_bit = 0;
    localparam int tx_start_bit = 1;
    // receive buffer fields
    localparam int rx_check_error_bit = 12;
    localparam int rx_end_msg_bit = 13;
    localparam int rx_full_bit = 15;
    // generator taps, as stage index fed by the feedback term
    localparam int tap_a_byte_count = 2;
    localparam int tap_b_byte_count = 15;
    localparam int tap_a_bit_oriented = 5;
    localparam int tap_b_bit_oriented = 12;
    // logical remainder expected after check bytes in bit-oriented mode
    localparam logic [15:0] good_remainder = 16'h1d0f;
    localparam logic [15:0] all_zero = 16'h0000;
    localparam logic [15:0] all_ones = 16'hffff;
    localparam logic [31:0] apb_zero = 32'h0000_0000;
    localparam logic [31:0] param_reset = 32'h0000_0000;

    // one shift of the generator; taps not selected pass data straight on
    function automatic logic [15:0] crc_step(input logic [15:0] cur, input logic din,
                                             input logic byte_mode, input logic fb_en);
        logic fb;
        logic [15:0] nxt;
        fb = fb_en & (din ^ cur[crc_width-1]);
        nxt = {cur[crc_width-2:0], fb};
        if (byte_mode) begin
            nxt[tap_a_byte_count] = cur[tap_a_byte_count-1] ^ fb;
            nxt[tap_b_byte_count] = cur[tap_b_byte_count-1] ^ fb;
        end else begin
            nxt[tap_a_bit_oriented] = cur[tap_a_bit_oriented-1] ^ fb;
            nxt[tap_b_bit_oriented] = cur[tap_b_bit_oriented-1] ^ fb;
        end
        return nxt;
    endfunction
endpackage

// [pin_sync.sv]
`timescale 1ns/10ps
module pin_sync
    import crc_link_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic dout
);
    logic s1_q, s2_q, s3_q, out_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // change counts once stages two and three agree
            if (s2_q == s3_q) begin
                out_q <= s3_q;
            end
        end
    end
    assign dout = out_q;
endmodule

// [tx_crc_gen.sv]
`timescale 1ns/10ps
module tx_crc_gen
    import crc_link_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic byte_mode,
    input wire logic bit_tick,
    input wire logic crc_shift_en,
    input wire logic fb_en,
    input wire logic tx_serial_out,
    input wire logic clear_req,
    output logic [15:0] crc_logical,
    output logic tx_crc_msb_out
);
    // stored at line level; bit-oriented mode keeps logical zero as high
    logic [15:0] level_q;
    logic [15:0] logical;
    logic [15:0] clear_level;
    assign logical = byte_mode ? level_q : ~level_q;
    assign clear_level = byte_mode ? all_zero : ~all_ones;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= all_zero;
        end else if (clear_req) begin
            level_q <= clear_level;
        end else if (bit_tick && crc_shift_en) begin
            level_q <= byte_mode ? crc_step(logical, tx_serial_out, byte_mode, fb_en)
                                 : ~crc_step(logical, tx_serial_out, byte_mode, fb_en);
        end
    end
    assign crc_logical = logical;
    // check sequence leaves inverted in bit-oriented mode
    assign tx_crc_msb_out = byte_mode ? logical[crc_width-1] : ~logical[crc_width-1];
endmodule

// [serial_link_crc_gen_check.sv]
`timescale 1ns/10ps
// Function
// - byte-count mode tests receive CRC every character
// - zero register at character end sets flag
// - check only while message active
// - CRC-disable control suppresses the flag
// - bit-oriented: flag error unless remainder matches
// - bit-oriented compare qualified by closing flag
// - stored polarity per mode; compare logical values
// - byte-count flag loads with its character
// - bit-oriented flag shown with end of message
// - parameter bit 15 selects byte-count mode
// - byte-count taps at input, bit 2, 15
// - bit-oriented taps at input, bit 5, 12
// - unused taps act as plain shift stages
// - shift once per bit time when enabled
// - clear to zeros or ones by mode
// - clear on synchronised start of message
// - byte-count: clear when sending-check state ends
// - check result held in buffer bit 12
// - input is data xor bit 15 output
// - bit-oriented check sequence sent complemented
// - data unaltered; check shifted out, feedback off
module serial_link_crc_gen_check
    import crc_link_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_bit_tick,
    input wire logic tx_data_bit,
    input wire logic tx_crc_shift_en,
    input wire logic sending_check_state,
    input wire logic synced_start_of_message,
    output logic tx_line_bit,
    output logic tx_start_of_message,
    output logic [15:0] tx_crc_register,
    input wire logic rx_char_load,
    input wire logic [7:0] rx_char,
    input wire logic [15:0] rx_crc_level,
    input wire logic message_active,
    input wire logic character_complete,
    input wire logic closing_flag_seen,
    input wire logic receive_end_of_message,
    output logic rx_check_flag
);
    logic [31:0] param_q;
    logic crc_disable_q;
    logic tx_start_of_message_q;
    logic [15:0] rxbuf_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic tx_line_q;
    logic [15:0] txcrc_q;
    logic sending_prev_q;
    logic synced_start_of_message_prev_q;
    logic synced_start_of_message_sync;

    // start-of-message arrives from the bit-sync side, another clock
    pin_sync u_synced_start_of_message_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(synced_start_of_message),
        .dout(synced_start_of_message_sync)
    );

    wire byte_mode = param_q[byte_count_protocol_bit];

    // apb decode
    wire setup_phase = psel & ~penable;
    wire access = psel & penable;
    wire hit_param = paddr == param_reg_addr;
    wire hit_ctrl = paddr == ctrl_reg_addr;
    wire hit_rxbuf = paddr == rxbuf_reg_addr;
    wire hit_txcrc = paddr == txcrc_reg_addr;
    wire hit_rxcrc = paddr == rxcrc_reg_addr;
    wire mapped = hit_param | hit_ctrl | hit_rxbuf | hit_txcrc | hit_rxcrc;
    wire wr_ok = access & pready_q & pwrite & mapped;
    wire [31:0] ctrl_view = {30'h0000_0000, tx_start_of_message_q, crc_disable_q};
    wire [15:0] rx_logical = byte_mode ? rx_crc_level : ~rx_crc_level;
    wire [31:0] rd_mux = hit_param ? param_q :
                         hit_ctrl ? ctrl_view :
                         hit_rxbuf ? {16'h0000, rxbuf_q} :
                         hit_txcrc ? {16'h0000, txcrc_q} :
                         hit_rxcrc ? {16'h0000, rx_logical} : apb_zero;

    // no wait state: answer registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= apb_zero;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase & ~mapped;
            prdata_q <= (setup_phase & ~pwrite) ? rd_mux : apb_zero;
        end
    end

    // receive error detection
    wire rx_zero = rx_logical == all_zero;
    wire rx_good_rem = rx_logical == good_remainder;
    wire check_window = message_active & ~crc_disable_q & character_complete;
    wire byte_flag = check_window & rx_zero;
    wire bit_flag = check_window & closing_flag_seen & ~rx_good_rem;
    wire check_result = byte_mode ? byte_flag : bit_flag;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param_q <= param_reset;
            crc_disable_q <= 1'b0;
            rxbuf_q <= all_zero;
        end else begin
            if (wr_ok && hit_param) begin
                param_q <= pwdata;
            end
            if (wr_ok && hit_ctrl) begin
                crc_disable_q <= pwdata[crc_disable_bit];
            end
            if (rx_char_load) begin
                rxbuf_q <= all_zero;
                rxbuf_q[data_width-1:0] <= rx_char;
                rxbuf_q[rx_check_error_bit] <= check_result;
                rxbuf_q[rx_end_msg_bit] <= receive_end_of_message;
                rxbuf_q[rx_full_bit] <= 1'b1;
            end
        end
    end

    // start control: software sets, synced echo clears; a set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_start_of_message_q <= 1'b0;
        end else if (wr_ok && hit_ctrl && pwdata[tx_start_bit]) begin
            tx_start_of_message_q <= 1'b1;
        end else if (synced_start_of_message_sync) begin
            tx_start_of_message_q <= 1'b0;
        end
    end

    // transmit generator
    wire synced_start_of_message_rise = synced_start_of_message_sync & ~synced_start_of_message_prev_q;
    wire check_fall = ~sending_check_state & sending_prev_q & byte_mode;
    wire [15:0] crc_now;
    wire crc_msb;
    tx_crc_gen u_tx_crc (
        .pclk(pclk),
        .presetn(presetn),
        .byte_mode(byte_mode),
        .bit_tick(tx_bit_tick),
        .crc_shift_en(tx_crc_shift_en),
        .fb_en(~sending_check_state),
        .tx_serial_out(tx_data_bit),
        .clear_req(synced_start_of_message_rise | check_fall),
        .crc_logical(crc_now),
        .tx_crc_msb_out(crc_msb)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_line_q <= 1'b0;
            txcrc_q <= all_zero;
            sending_prev_q <= 1'b0;
            synced_start_of_message_prev_q <= 1'b0;
        end else begin
            // data passes unaltered; check bits follow from the generator
            tx_line_q <= sending_check_state ? crc_msb : tx_data_bit;
            txcrc_q <= crc_now;
            sending_prev_q <= sending_check_state;
            synced_start_of_message_prev_q <= synced_start_of_message_sync;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_line_bit = tx_line_q;
    assign tx_start_of_message = tx_start_of_message_q;
    assign tx_crc_register = txcrc_q;
    assign rx_check_flag = rxbuf_q[rx_check_error_bit];

    flag_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_char_load |=> rx_check_flag == $past(check_result))
        else $error("check flag not loaded with character");
    flag_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_char_load && crc_disable_q) |=> !rx_check_flag)
        else $error("check flag set while disabled");
    flag_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_char_load && byte_mode && message_active && !crc_disable_q && character_complete
         && rx_logical == all_zero) |=> rx_check_flag)
        else $error("zero remainder not flagged");
    flag_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_char_load && !byte_mode && rx_logical == good_remainder) |=> !rx_check_flag)
        else $error("good remainder flagged as error");
    inactive_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_char_load && !message_active) |=> !rx_check_flag)
        else $error("flag set outside message");
    line_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sending_check_state |=> tx_line_bit == $past(tx_data_bit))
        else $error("data altered on line");
    start_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(synced_start_of_message_sync) |=> ##1 tx_crc_register == (byte_mode ? all_zero : all_ones))
        else $error("generator not cleared at start");
    // a clear or a mode write may change the logical view, so both leave the antecedent
    hold_crc_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!(tx_bit_tick && tx_crc_shift_en) && !synced_start_of_message_rise && !check_fall && !(wr_ok && hit_param))
        |=> crc_now == $past(crc_now))
        else $error("generator moved without enable");
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("apb answer late");
endmodule

// [serial_datapath_model.sv]
`timescale 1ns/10ps
module serial_datapath_model (
    input wire logic pclk,
    input wire logic tx_start_of_message,
    output logic tx_bit_tick,
    output logic tx_data_bit,
    output logic tx_crc_shift_en,
    output logic sending_check_state,
    output logic synced_start_of_message,
    output logic rx_char_load,
    output logic [7:0] rx_char,
    output logic [15:0] rx_crc_level,
    output logic message_active,
    output logic character_complete,
    output logic closing_flag_seen,
    output logic receive_end_of_message
);
    logic busy;
    initial begin
        {tx_bit_tick, tx_data_bit, tx_crc_shift_en, sending_check_state, synced_start_of_message} = '0;
        {rx_char_load, rx_char, rx_crc_level, message_active, character_complete} = '0;
        {closing_flag_seen, receive_end_of_message, busy} = '0;
    end
    // plain flop only; the block owns the real resync
    always @(posedge pclk) synced_start_of_message <= tx_start_of_message;
    // idle line toggles so a stale bit never looks valid
    always @(posedge pclk) if (!busy) tx_data_bit <= ~tx_data_bit;

    task automatic send_byte(input logic [7:0] b);
        busy = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            @(posedge pclk);
            tx_data_bit <= b[i];
            tx_bit_tick <= 1'b1;
            tx_crc_shift_en <= 1'b1;
            @(posedge pclk);
            tx_bit_tick <= 1'b0;
        end
        @(posedge pclk);
        tx_crc_shift_en <= 1'b0;
        busy = 1'b0;
    endtask

    task automatic set_check(input logic v);
        @(posedge pclk);
        sending_check_state <= v;
    endtask

    task automatic rx_load(input logic [15:0] lvl, input logic [3:0] st);
        @(posedge pclk);
        rx_char <= lvl[7:0];
        rx_crc_level <= lvl;
        {message_active, character_complete, closing_flag_seen, receive_end_of_message} <= st;
        rx_char_load <= 1'b1;
        @(posedge pclk);
        rx_char_load <= 1'b0;
        // value is gone once the load is over
        rx_crc_level <= ~lvl;
    endtask
endmodule

// [tb_serial_link_crc_gen_check.sv]
`timescale 1ns/10ps
module tb_serial_link_crc_gen_check import crc_link_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic tx_bit_tick, tx_data_bit, tx_crc_shift_en, sending_check_state, synced_start_of_message;
    logic tx_line_bit, tx_start_of_message, rx_char_load, rx_check_flag;
    logic message_active, character_complete, closing_flag_seen, receive_end_of_message;
    logic [7:0] rx_char;
    logic [15:0] tx_crc_register, rx_crc_level;
    int num_errors = 0;
    int total_checks = 0;

    serial_link_crc_gen_check serial_link_crc_gen_check_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_bit_tick, .tx_data_bit, .tx_crc_shift_en,
        .sending_check_state, .synced_start_of_message, .tx_line_bit, .tx_start_of_message,
        .tx_crc_register, .rx_char_load, .rx_char, .rx_crc_level, .message_active,
        .character_complete, .closing_flag_seen, .receive_end_of_message, .rx_check_flag);
    serial_datapath_model serial_datapath_model_i (.pclk, .tx_start_of_message, .tx_bit_tick,
        .tx_data_bit, .tx_crc_shift_en, .sending_check_state, .synced_start_of_message, .rx_char_load,
        .rx_char, .rx_crc_level, .message_active, .character_complete, .closing_flag_seen,
        .receive_end_of_message);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            $display("[ERR] apb wait expected 1 seen %b", pready);
            complete_run();
        end
    endtask

    // independent reference, msb first
    function automatic logic [15:0] ref_crc(input logic [15:0] c, input logic [7:0] b, input logic bm);
        logic f;
        for (int i = 7; i >= 0; i--) begin
            f = b[i] ^ c[15];
            c = {c[14:0], f};
            if (bm) begin
                c[2] = c[2] ^ f;
                c[15] = c[15] ^ f;
            end else begin
                c[5] = c[5] ^ f;
                c[12] = c[12] ^ f;
            end
        end
        return c;
    endfunction

    task automatic regs_scn;
        apb(1'b0, param_reg_addr, apb_zero);
        chk("param reset", param_reset, rd);
        apb(1'b1, 8'h20, 32'hffff_ffff);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'b0, 8'h20, apb_zero);
        chk("unmapped read", apb_zero, rd);
        apb(1'b1, param_reg_addr, 32'h0000_8000);
        apb(1'b0, param_reg_addr, apb_zero);
        chk("param bit", 32'h0000_8000, rd);
    endtask

    task automatic tx_scn(input logic bm, input logic [15:0] clr);
        logic [15:0] exp;
        apb(1'b1, param_reg_addr, {16'h0, bm, 15'h0});
        apb(1'b1, ctrl_reg_addr, 32'h2);
        repeat (12) @(posedge pclk);
        chk("start control", apb_zero, {31'h0, tx_start_of_message});
        chk("crc clear", {16'h0, clr}, {16'h0, tx_crc_register});
        serial_datapath_model_i.send_byte(8'h31);
        serial_datapath_model_i.send_byte(8'hc5);
        repeat (3) @(posedge pclk);
        exp = ref_crc(ref_crc(clr, 8'h31, bm), 8'hc5, bm);
        chk("crc value", {16'h0, exp}, {16'h0, tx_crc_register});
        serial_datapath_model_i.set_check(1'b1);
        repeat (3) @(posedge pclk);
        chk("line check bit", {31'h0, exp[15] ^ ~bm}, {31'h0, tx_line_bit});
        serial_datapath_model_i.set_check(1'b0);
        repeat (3) @(posedge pclk);
        chk("crc after check", {16'h0, bm ? all_zero : exp}, {16'h0, tx_crc_register});
    endtask

    // st holds active, complete, closing flag, end of message
    task automatic rx_scn(input logic bm, input logic dis, input logic [15:0] lg, input logic [3:0] st,
                          input logic exp);
        logic [15:0] lvl;
        lvl = bm ? lg : ~lg;
        apb(1'b1, param_reg_addr, {16'h0, bm, 15'h0});
        apb(1'b1, ctrl_reg_addr, {31'h0, dis});
        serial_datapath_model_i.rx_load(lvl, st);
        @(posedge pclk);
        chk("rx flag", {31'h0, exp}, {31'h0, rx_check_flag});
        apb(1'b0, rxbuf_reg_addr, apb_zero);
        chk("rx buffer", {16'h0, 2'b10, st[0], exp, 4'h0, lvl[7:0]}, rd);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        regs_scn();
        tx_scn(1'b1, all_zero);
        tx_scn(1'b0, all_ones);
        rx_scn(1'b1, 1'b0, 16'h0000, 4'b1100, 1'b1);
        rx_scn(1'b1, 1'b0, 16'h0001, 4'b1100, 1'b0);
        rx_scn(1'b1, 1'b0, 16'h0000, 4'b0100, 1'b0);
        rx_scn(1'b1, 1'b1, 16'h0000, 4'b1100, 1'b0);
        rx_scn(1'b1, 1'b0, 16'h0000, 4'b1000, 1'b0);
        rx_scn(1'b0, 1'b0, good_remainder, 4'b1111, 1'b0);
        rx_scn(1'b0, 1'b0, 16'h1d07, 4'b1111, 1'b1);
        rx_scn(1'b0, 1'b0, 16'h1d07, 4'b1101, 1'b0);
        rx_scn(1'b0, 1'b0, all_zero, 4'b1111, 1'b1);
        complete_run();
    end
endmodule
